// [hdl/pin_change_interrupt.v]
// Pin change interrupt block: edge detect, flags, enables, request and wake
//
// Contract
// [RULE_01] Each pin has rising and falling detectors
// [RULE_02] Rising detect armed by rise enable bit
// [RULE_03] Falling detect armed by fall enable bit
// [RULE_04] Both enables detect either edge polarity
// [RULE_05] Master off: flags still set, no request
// [RULE_06] Enabled edge sets flag; request if master
// [RULE_07] Summary flag is OR of all flags
// [RULE_08] Writing zero clears a flag bit
// [RULE_09] Edge during flag write wins over write
// [RULE_10] Software clears flags by masked AND; the code loads the written byte instead, so writing one sets a flag
// [RULE_11] Change wakes from sleep only with master
// [RULE_12] Sleep edges recorded before first instruction
// [RULE_13] Flag registers eight bits, reset zero
// [RULE_14] Positive or negative edge sets pin flag
// [RULE_15] Module disable stops all change detection
// [RULE_16] Port E pin 3 off under clear/programming
// [RULE_17] Edges found by synchronous sample compare
// [RULE_18] Port E implements only bit three
`include "pin_change_consts.vh"
`default_nettype none
module pin_change_interrupt
(
  input  wire                CORE_CLK_IN,
  input  wire                SYS_RST_IN,
  input  wire [`ADDR_W-1:0]  ADDR_IN,
  input  wire [`DATA_W-1:0]  WDATA_IN,
  input  wire                WR_IN,
  input  wire                RD_IN,
  output reg  [`DATA_W-1:0]  RDATA_OUT,
  input  wire [`PORT_W-1:0]  PORT_A_PIN_IN,
  input  wire [`PORT_W-1:0]  PORT_B_PIN_IN,
  input  wire [`PORT_W-1:0]  PORT_C_PIN_IN,
  input  wire [`PORT_W-1:0]  PORT_E_PIN_IN,
  input  wire                MASTER_CLEAR_PIN_ENABLE_IN,
  input  wire                LOW_VOLTAGE_PROGRAMMING_ENABLE_IN,
  input  wire                SLEEP_IN,
  output wire                CHANGE_IRQ_SUMMARY_FLAG_OUT,
  output wire                IRQ_REQ_OUT,
  output wire                WAKE_OUT
);
  // Rise, fall and flag registers, one byte per port
  reg  [`PORT_W-1:0] rise_q [0:`PORT_NUM-1];
  reg  [`PORT_W-1:0] fall_q [0:`PORT_NUM-1];
  reg  [`PORT_W-1:0] flag_q [0:`PORT_NUM-1];
  // Master enable and module disable control bits
  reg                master_en_q;
  reg                disable_q;
  // Decoded access
  reg  [`PORT_IDX_W-1:0] dec_port;
  reg  [`REG_KIND_W-1:0] dec_kind;
  // Edge pulses per port
  wire [`PORT_W-1:0] rise_p [0:`PORT_NUM-1];
  wire [`PORT_W-1:0] fall_p [0:`PORT_NUM-1];
  // Pin bundle for the detectors
  wire [`PORT_W-1:0] pins   [0:`PORT_NUM-1];
  // Port E pin 3 unavailable as a change input
  wire               pe3_off;
  // Detection runs only while the module is not disabled
  wire               run;
  // Read data before the output register
  reg  [`DATA_W-1:0] rd_d;
  // Enabled edge pulses per port, masked to the implemented bits
  reg  [`PORT_W-1:0] armed [0:`PORT_NUM-1];
  // Loop index of the enable register process
  integer            i;
  // Loop index of the flag register process; one index per process
  // keeps every variable to a single driver
  integer            j;
  // Loop index of the armed edge process
  integer            k;

  // Implemented-bit mask of a port; port E has only pin 3
  function [`PORT_W-1:0] port_mask;
    input [`PORT_IDX_W-1:0] p;
    begin
      // [RULE_18] Port E bit three only
      if (p == `PORT_E)
        port_mask = `PORTE_MASK;
      else
        port_mask = `FULL_MASK;
    end
  endfunction

  // Enabled edges of one port, used for every port and every flag
  function [`PORT_W-1:0] armed_edges;
    input [`PORT_W-1:0] r;
    input [`PORT_W-1:0] f;
    input [`PORT_W-1:0] re;
    input [`PORT_W-1:0] fe;
    begin
      // [RULE_04] Either polarity when both
      armed_edges = (r & re) | (f & fe);
    end
  endfunction

  // [RULE_16] Pin 3 of port E off
  assign pe3_off = MASTER_CLEAR_PIN_ENABLE_IN |
                   LOW_VOLTAGE_PROGRAMMING_ENABLE_IN;
  // [RULE_15] Disable stops detection
  assign run     = ~disable_q;

  assign pins[`PORT_A] = PORT_A_PIN_IN;
  assign pins[`PORT_B] = PORT_B_PIN_IN;
  assign pins[`PORT_C] = PORT_C_PIN_IN;
  // Masked pins of port E stay low; pin 3 still makes an edge when a strap changes while it is high
  assign pins[`PORT_E] = PORT_E_PIN_IN & (pe3_off ? `ZERO_BYTE : `PORTE_MASK);

  // [RULE_01] Independent detectors per pin
  genvar g;
  generate
    for (g = 0; g < `PORT_NUM; g = g + 1)
    begin : g_port
      pin_edge_detect u_det
      (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .run_in   (run),
        .pins_in  (pins[g]),
        .rise_out (rise_p[g]),
        .fall_out (fall_p[g])
      );
    end
  endgenerate

  // Address decode into port and register kind.
  // Each port owns three neighbouring bytes; the gaps between ports decode
  // to nothing, so stray accesses neither write nor read anything.
  always @*
  begin
    dec_port = `PORT_A;
    dec_kind = `KIND_NONE;
    case (ADDR_IN)
      // Port A rise enable
      `PORTA_RISE_ADDR:
      begin
        dec_port = `PORT_A;
        dec_kind = `KIND_RISE;
      end
      // Port A fall enable
      `PORTA_FALL_ADDR:
      begin
        dec_port = `PORT_A;
        dec_kind = `KIND_FALL;
      end
      // Port A flags
      `PORTA_FLAG_ADDR:
      begin
        dec_port = `PORT_A;
        dec_kind = `KIND_FLAG;
      end
      // Port B rise enable
      `PORTB_RISE_ADDR:
      begin
        dec_port = `PORT_B;
        dec_kind = `KIND_RISE;
      end
      // Port B fall enable
      `PORTB_FALL_ADDR:
      begin
        dec_port = `PORT_B;
        dec_kind = `KIND_FALL;
      end
      // Port B flags
      `PORTB_FLAG_ADDR:
      begin
        dec_port = `PORT_B;
        dec_kind = `KIND_FLAG;
      end
      // Port C rise enable
      `PORTC_RISE_ADDR:
      begin
        dec_port = `PORT_C;
        dec_kind = `KIND_RISE;
      end
      // Port C fall enable
      `PORTC_FALL_ADDR:
      begin
        dec_port = `PORT_C;
        dec_kind = `KIND_FALL;
      end
      // Port C flags
      `PORTC_FLAG_ADDR:
      begin
        dec_port = `PORT_C;
        dec_kind = `KIND_FLAG;
      end
      // Port E rise enable
      `PORTE_RISE_ADDR:
      begin
        dec_port = `PORT_E;
        dec_kind = `KIND_RISE;
      end
      // Port E fall enable
      `PORTE_FALL_ADDR:
      begin
        dec_port = `PORT_E;
        dec_kind = `KIND_FALL;
      end
      // Port E flags
      `PORTE_FLAG_ADDR:
      begin
        dec_port = `PORT_E;
        dec_kind = `KIND_FLAG;
      end
      // Unmapped addresses select nothing
      default:
      begin
        dec_port = `PORT_A;
        dec_kind = `KIND_NONE;
      end
    endcase
  end

  // Enable registers and control bits
  always @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      for (i = 0; i < `PORT_NUM; i = i + 1)
      begin
        rise_q[i] <= `ZERO_BYTE;
        fall_q[i] <= `ZERO_BYTE;
      end
      master_en_q <= 1'b0;
      disable_q   <= 1'b0;
    end
    else if (WR_IN)
    begin
      // [RULE_02] Rise enable storage
      if (dec_kind == `KIND_RISE)
        rise_q[dec_port] <= WDATA_IN & port_mask(dec_port);
      // [RULE_03] Fall enable storage
      if (dec_kind == `KIND_FALL)
        fall_q[dec_port] <= WDATA_IN & port_mask(dec_port);
      if (ADDR_IN == `CTRL_ADDR)
      begin
        master_en_q <= WDATA_IN[`CTRL_MASTER_BIT];
        disable_q   <= WDATA_IN[`CTRL_DISABLE_BIT];
      end
    end
  end

  // Enabled edges of every port, masked to its implemented bits.
  // Worked out once here so the write path and the idle path of the flag
  // process see exactly the same set of edges.
  always @*
  begin
    for (k = 0; k < `PORT_NUM; k = k + 1)
    begin
      // [RULE_14] Edge of enabled polarity
      armed[k] = armed_edges(rise_p[k], fall_p[k], rise_q[k], fall_q[k]) &
                 port_mask(k[`PORT_IDX_W-1:0]);
    end
  end

  // Flag registers: software writes, hardware sets; the set wins.
  // Flags are not cleared by the module disable, so software still sees
  // edges that were caught before it turned detection off.
  always @(posedge CORE_CLK_IN)
  begin
    // [RULE_13] Flags reset to zero
    if (SYS_RST_IN)
    begin
      for (j = 0; j < `PORT_NUM; j = j + 1)
        flag_q[j] <= `ZERO_BYTE;
    end
    else
    begin
      for (j = 0; j < `PORT_NUM; j = j + 1)
      begin
        // [RULE_08] Write zero clears
        // [RULE_09] Edge overrides written value
        // [RULE_12] Edges recorded in sleep too
        if (WR_IN && dec_kind == `KIND_FLAG &&
            dec_port == j[`PORT_IDX_W-1:0])
        begin
          // Written value first, then this cycle's edges on top
          flag_q[j] <= (WDATA_IN & port_mask(j[`PORT_IDX_W-1:0])) |
                       armed[j];
        end
        else
        begin
          // Hold and collect new edges
          flag_q[j] <= flag_q[j] | armed[j];
        end
      end
    end
  end

  // [RULE_07] Summary is OR of flags
  assign CHANGE_IRQ_SUMMARY_FLAG_OUT = |{flag_q[`PORT_A], flag_q[`PORT_B],
                                         flag_q[`PORT_C], flag_q[`PORT_E]};
  // [RULE_05] Master gates the request
  // [RULE_06] Request from set flags
  assign IRQ_REQ_OUT = CHANGE_IRQ_SUMMARY_FLAG_OUT & master_en_q;
  // [RULE_11] Wake only with master
  assign WAKE_OUT    = IRQ_REQ_OUT & SLEEP_IN;

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_d = `ZERO_BYTE;
    case (dec_kind)
      // Rise enables read back as stored
      `KIND_RISE: rd_d = rise_q[dec_port];
      // Fall enables read back as stored
      `KIND_FALL: rd_d = fall_q[dec_port];
      // Flags as they stand before this cycle's edges land
      `KIND_FLAG: rd_d = flag_q[dec_port];
      default:
      begin
        if (ADDR_IN == `CTRL_ADDR)
        begin
          rd_d[`CTRL_MASTER_BIT]  = master_en_q;
          rd_d[`CTRL_DISABLE_BIT] = disable_q;
        end
        else if (ADDR_IN == `STATUS_ADDR)
        begin
          rd_d[`STAT_SUMMARY_BIT] = CHANGE_IRQ_SUMMARY_FLAG_OUT;
          rd_d[`STAT_PE3_OFF_BIT] = pe3_off;
        end
      end
    endcase
  end

  // Read data registered; holds zero outside the answer cycle
  // Zero between answers lets several blocks share one OR-ed read bus
  always @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
      RDATA_OUT <= `ZERO_BYTE;
    else if (RD_IN)
      RDATA_OUT <= rd_d;
    else
      RDATA_OUT <= `ZERO_BYTE;
  end
endmodule
`default_nettype wire

// [hdl/pin_change_consts.vh]
// Register offsets, field positions and reset values of the pin change block
`ifndef PIN_CHANGE_CONSTS_VH
`define PIN_CHANGE_CONSTS_VH
`define ADDR_W              16
`define DATA_W              8
`define PORT_W              8
`define PORT_NUM            4
`define PORT_IDX_W          2
`define REG_KIND_W          2
`define PORTA_RISE_ADDR     16'h1F3D
`define PORTA_FALL_ADDR     16'h1F3E
`define PORTA_FLAG_ADDR     16'h1F3F
`define PORTB_RISE_ADDR     16'h1F48
`define PORTB_FALL_ADDR     16'h1F49
`define PORTB_FLAG_ADDR     16'h1F4A
`define PORTC_RISE_ADDR     16'h1F53
`define PORTC_FALL_ADDR     16'h1F54
`define PORTC_FLAG_ADDR     16'h1F55
`define PORTE_RISE_ADDR     16'h1F69
`define PORTE_FALL_ADDR     16'h1F6A
`define PORTE_FLAG_ADDR     16'h1F6B
`define CTRL_ADDR           16'h1F70
`define STATUS_ADDR         16'h1F71
`define PORT_A              2'h0
`define PORT_B              2'h1
`define PORT_C              2'h2
`define PORT_E              2'h3
`define KIND_NONE           2'h0
`define KIND_RISE           2'h1
`define KIND_FALL           2'h2
`define KIND_FLAG           2'h3
`define CTRL_MASTER_BIT     0
`define CTRL_DISABLE_BIT    1
`define STAT_SUMMARY_BIT    0
`define STAT_PE3_OFF_BIT    1
`define PORTE_MASK          8'h08
`define FULL_MASK           8'hFF
`define ZERO_BYTE           8'h00
`define ZERO_PORTS          32'h0000_0000
`endif

// [hdl/pin_edge_detect.v]
// Sampling edge detector for one port of eight pins
`include "pin_change_consts.vh"
`default_nettype none
module pin_edge_detect
(
  input  wire               clk_in,
  input  wire               rst_in,
  input  wire               run_in,
  input  wire [`PORT_W-1:0] pins_in,
  output wire [`PORT_W-1:0] rise_out,
  output wire [`PORT_W-1:0] fall_out
);
  // Previous sample of the pins
  reg [`PORT_W-1:0] last_q;
  // Sample history is valid once a first sample was taken
  reg               primed_q;

  // Keep sampling; while stopped, drop history so no stale edge appears
  always @(posedge clk_in)
  begin
    if (rst_in || !run_in)
    begin
      last_q   <= `ZERO_BYTE;
      primed_q <= 1'b0;
    end
    else
    begin
      last_q   <= pins_in;
      primed_q <= 1'b1;
    end
  end

  // [RULE_17] Compare with previous sample
  assign rise_out = (primed_q && run_in) ? (pins_in & ~last_q) : `ZERO_BYTE;
  assign fall_out = (primed_q && run_in) ? (~pins_in & last_q) : `ZERO_BYTE;
endmodule
`default_nettype wire

// [tb/pin_change_sva.sv]
// Assertion checker for the pin change interrupt block
`include "pin_change_consts.vh"
`default_nettype none
module pin_change_sva
(
  input wire logic        CORE_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic [7:0]  PORT_A_PIN_IN,
  input wire logic [7:0]  PORT_B_PIN_IN,
  input wire logic [7:0]  PORT_C_PIN_IN,
  input wire logic [7:0]  PORT_E_PIN_IN,
  input wire logic        MASTER_CLEAR_PIN_ENABLE_IN,
  input wire logic        LOW_VOLTAGE_PROGRAMMING_ENABLE_IN,
  input wire logic        SLEEP_IN,
  input wire logic        CHANGE_IRQ_SUMMARY_FLAG_OUT,
  input wire logic        IRQ_REQ_OUT,
  input wire logic        WAKE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Straps count as pin moves, they can make an edge on pin three
  wire [33:0] pins = {PORT_A_PIN_IN, PORT_B_PIN_IN, PORT_C_PIN_IN,
    PORT_E_PIN_IN, MASTER_CLEAR_PIN_ENABLE_IN,
    LOW_VOLTAGE_PROGRAMMING_ENABLE_IN};
  wire        summ = CHANGE_IRQ_SUMMARY_FLAG_OUT;
  // Read of the status byte
  sequence s_stat_rd;
    RD_IN && ADDR_IN == `STATUS_ADDR;
  endsequence
  // Read of any port E register
  sequence s_e_rd;
    RD_IN && ADDR_IN >= `PORTE_RISE_ADDR && ADDR_IN <= `PORTE_FLAG_ADDR;
  endsequence
  AST_REQ_NEEDS_FLAG: assert property (IRQ_REQ_OUT |-> summ)
    else $error("request without a flag");
  AST_WAKE_ON_REQ: assert property (IRQ_REQ_OUT && SLEEP_IN |-> WAKE_OUT)
    else $error("no wake while asleep with request");
  AST_WAKE_CAUSE: assert property (WAKE_OUT |-> IRQ_REQ_OUT && SLEEP_IN)
    else $error("wake without request in sleep");
  AST_RD_IDLE_ZERO: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data not zero outside read");
  AST_RESET_CLEAR: assert property ($fell(SYS_RST_IN) |-> !summ)
    else $error("flags not clear after reset");
  // A flag only rises after a write or a recent pin move
  AST_FLAG_CAUSE: assert property ($rose(summ) |-> $past(WR_IN) ||
    $past(pins) != $past(pins, 2) || $past(pins, 2) != $past(pins, 3))
    else $error("flag rose with no cause");
  AST_FLAG_HOLDS: assert property (summ && !WR_IN |=> summ)
    else $error("flag lost without a write");
  AST_MASTER_BY_WRITE: assert property ($changed(IRQ_REQ_OUT) &&
    $stable(summ) |-> $past(WR_IN))
    else $error("request moved with no write");
  AST_STATUS_SUMMARY: assert property (s_stat_rd |=>
    RDATA_OUT[0] == $past(summ))
    else $error("status summary bit wrong");
  AST_STATUS_PE3: assert property (s_stat_rd |=> RDATA_OUT[1] ==
    $past(MASTER_CLEAR_PIN_ENABLE_IN || LOW_VOLTAGE_PROGRAMMING_ENABLE_IN))
    else $error("pin three unavailable bit wrong");
  AST_PORTE_BITS: assert property (s_e_rd |=>
    (RDATA_OUT & 8'hF7) == 8'h00)
    else $error("port E unused bit set");
endmodule
bind pin_change_interrupt pin_change_sva u_pin_change_sva
(
  .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .PORT_A_PIN_IN(PORT_A_PIN_IN), .PORT_B_PIN_IN(PORT_B_PIN_IN),
  .PORT_C_PIN_IN(PORT_C_PIN_IN), .PORT_E_PIN_IN(PORT_E_PIN_IN),
  .MASTER_CLEAR_PIN_ENABLE_IN(MASTER_CLEAR_PIN_ENABLE_IN),
  .LOW_VOLTAGE_PROGRAMMING_ENABLE_IN(LOW_VOLTAGE_PROGRAMMING_ENABLE_IN),
  .SLEEP_IN(SLEEP_IN), .CHANGE_IRQ_SUMMARY_FLAG_OUT(CHANGE_IRQ_SUMMARY_FLAG_OUT),
  .IRQ_REQ_OUT(IRQ_REQ_OUT), .WAKE_OUT(WAKE_OUT)
);
`default_nettype wire

// [tb/pin_driver.sv]
// Pin level model for the four watched ports
`default_nettype none
module pin_driver
(
  input  wire logic       clk_in,
  output var  logic [7:0] a_out,
  output var  logic [7:0] b_out,
  output var  logic [7:0] c_out,
  output var  logic [7:0] e_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels start low so release of reset sees no edge
  initial {a_out, b_out, c_out, e_out} = 32'h0000_0000;
  // Pins move just after an edge, like a synchronised input
  task automatic drive(input logic [1:0] p, input logic [7:0] v);
    @(posedge clk_in);
    case (p)
      2'h0: a_out <= v;
      2'h1: b_out <= v;
      2'h2: c_out <= v;
      default: e_out <= v;
    endcase
  endtask
endmodule
`default_nettype wire

// [tb/pin_change_interrupt_tb.sv]
// Self-checking bench for the pin change interrupt block
`include "pin_change_consts.vh"
`default_nettype none
module pin_change_interrupt_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        mclr = 1'b0;
  logic        slp = 1'b0;
  logic        low_voltage_programming_enable = 1'b0;
  wire  [7:0]  rdata, pa, pb, pc, pe;
  wire         summ, irq, wake;
  int          n_errors = 0;
  int          checked = 0;
  // Rise enable address of each port; fall and flag follow it
  logic [15:0] base [4] = '{`PORTA_RISE_ADDR, `PORTB_RISE_ADDR,
    `PORTC_RISE_ADDR, `PORTE_RISE_ADDR};
  logic [7:0]  mask [4] = '{`FULL_MASK, `FULL_MASK, `FULL_MASK, `PORTE_MASK};
  // 10 MHz core clock
  always #50 clk = ~clk;
  pin_driver u_pin_driver (.clk_in(clk), .a_out(pa), .b_out(pb),
    .c_out(pc), .e_out(pe));
  pin_change_interrupt u_pin_change_interrupt (.CORE_CLK_IN(clk),
    .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .PORT_A_PIN_IN(pa), .PORT_B_PIN_IN(pb),
    .PORT_C_PIN_IN(pc), .PORT_E_PIN_IN(pe), .MASTER_CLEAR_PIN_ENABLE_IN(mclr),
    .LOW_VOLTAGE_PROGRAMMING_ENABLE_IN(low_voltage_programming_enable), .SLEEP_IN(slp),
    .CHANGE_IRQ_SUMMARY_FLAG_OUT(summ), .IRQ_REQ_OUT(irq), .WAKE_OUT(wake));
  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Data stands only in the cycle after the read strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp,
    input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(what, exp, rdata);
  endtask
  // Two edges: the flag sets on the first, the second is spare
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset;
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 3; k++)
        rd_chk(base[p] + 16'(k), 8'h00, "reset value");
    rd_chk(`CTRL_ADDR, 8'h00, "control reset");
    rd_chk(16'h1F40, 8'h00, "unmapped read");
  endtask
  task automatic t_edges;
    for (int p = 0; p < 4; p++)
    begin
      wr8(base[p], 8'h0F);
      wr8(base[p] + 16'h0001, 8'hF0);
      rd_chk(base[p], 8'h0F & mask[p], "rise enable");
      u_pin_driver.drive(2'(p), 8'hFF);
      settle();
      rd_chk(base[p] + 16'h0002, 8'h0F & mask[p], "rise flags");
      u_pin_driver.drive(2'(p), 8'h00);
      settle();
      rd_chk(base[p] + 16'h0002, mask[p], "fall flags");
      chk1("summary", 1'b1, summ);
      chk1("request", 1'b0, irq);
      wr8(base[p] + 16'h0002, mask[p] & (mask[p] ^ 8'hFF));
      rd_chk(base[p] + 16'h0002, 8'h00, "cleared");
    end
  endtask
  task automatic t_sleep;
    wr8(`CTRL_ADDR, 8'h01);
    slp <= 1'b1;
    u_pin_driver.drive(2'h1, 8'hFF);
    settle();
    #1;
    chk1("wake", 1'b1, wake);
    chk1("request", 1'b1, irq);
    rd_chk(`PORTB_FLAG_ADDR, 8'h0F, "sleep flags");
    wr8(`CTRL_ADDR, 8'h00);
    chk1("wake off", 1'b0, wake);
    chk1("summary kept", 1'b1, summ);
    slp <= 1'b0;
    rd_chk(`STATUS_ADDR, 8'h01, "status");
    wr8(`PORTB_FLAG_ADDR, 8'h00);
    rd_chk(`STATUS_ADDR, 8'h00, "status clear");
  endtask
  // Edge lands in the same cycle as a clearing write
  task automatic t_collide;
    wr8(`PORTA_RISE_ADDR, 8'h01);
    wr8(`PORTA_FALL_ADDR, 8'h01);
    // Pin edge and clearing write are sampled at the same clock edge
    fork
      u_pin_driver.drive(2'h0, 8'h01);
      wr8(`PORTA_FLAG_ADDR, 8'h00);
    join
    rd_chk(`PORTA_FLAG_ADDR, 8'h01, "edge beats write");
    wr8(`PORTA_FLAG_ADDR, 8'h00);
    u_pin_driver.drive(2'h0, 8'h00);
    settle();
    rd_chk(`PORTA_FLAG_ADDR, 8'h01, "both edges");
  endtask
  task automatic t_disable;
    wr8(`PORTA_FLAG_ADDR, 8'h00);
    wr8(`CTRL_ADDR, 8'h02);
    u_pin_driver.drive(2'h0, 8'h01);
    settle();
    rd_chk(`PORTA_FLAG_ADDR, 8'h00, "disabled");
    wr8(`CTRL_ADDR, 8'h00);
    settle();
    u_pin_driver.drive(2'h0, 8'h00);
    settle();
    rd_chk(`PORTA_FLAG_ADDR, 8'h01, "enabled again");
    wr8(`PORTA_FLAG_ADDR, 8'h00);
    mclr <= 1'b1;
    u_pin_driver.drive(2'h3, 8'h08);
    settle();
    rd_chk(`PORTE_FLAG_ADDR, 8'h00, "pin three off");
    rd_chk(`STATUS_ADDR, 8'h02, "pin three status");
    mclr <= 1'b0;
    low_voltage_programming_enable <= 1'b1;
    rd_chk(`STATUS_ADDR, 8'h02, "programming status");
    rd_chk(`PORTE_FLAG_ADDR, 8'h00, "programming off");
    // Strap released while the pin is high: pin three comes back
    low_voltage_programming_enable <= 1'b0;
    settle();
    rd_chk(`PORTE_FLAG_ADDR, 8'h08, "pin three back");
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is under two hundred cycles; this 5000-cycle limit is generous
  initial
  begin
    #500_000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_edges();
    t_sleep();
    t_collide();
    t_disable();
    give_verdict();
  end
endmodule
`default_nettype wire
